//--- prc_consts.svh
// register offsets, field positions and reset values of the read buffer control block
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH

`define PRC_ADDR_W 12
`define PRC_CTRL_OFF 12'h040
`define PRC_STAT_OFF 12'h044

`define PRC_CTRL_RESET 32'h0000_0020
`define PRC_CTRL_WMASK 32'h0000_7fff

`define PRC_BIT_PARK 0
`define PRC_BIT_DYN_DIS 1
`define PRC_BIT_PRED_DIS 2
`define PRC_BIT_CFG_CONV 3
`define PRC_MRM_LO 4
`define PRC_MRL_LO 6
`define PRC_MR_LO 8
`define PRC_BIT_SDR 10
`define PRC_BIT_MALF 11
`define PRC_BCNT_LO 12

`define PRC_STAT_MTO 0
`define PRC_STAT_HELD 1
`define PRC_STAT_RETAIN 2

`define PRC_MODE_LINE 2'h0
`define PRC_MODE_01 2'h1
`define PRC_MODE_FULL 2'h2
`define PRC_MODE_11 2'h3

`define PRC_CMD_MR 2'h0
`define PRC_CMD_MRL 2'h1
`define PRC_CMD_MRM 2'h2

`define PRC_CFG_TOP 4'hf

`define PRC_RESP_OKAY 2'h0
`define PRC_RESP_SLVERR 2'h2

`endif

//--- prc_pkg.sv
// types shared by the read buffer control block
package prc_pkg;

  typedef enum logic [1:0] {
    PRC_FETCH_EXACT,
    PRC_FETCH_LINE,
    PRC_FETCH_FULL,
    PRC_FETCH_ONE_DW
  } prc_fetch_e;

  typedef enum logic [1:0] {
    PRC_IDLE,
    PRC_PENDING,
    PRC_READY,
    PRC_RETAIN
  } prc_state_e;

  typedef logic [12:0] prc_bytes_t;

endpackage : prc_pkg

//--- prc_bcnt_dec.sv
// decoder from the three-bit maximum read byte count code to bytes
`timescale 1ns/1ps
module prc_bcnt_dec (
  input wire logic [2:0] code,
  output prc_pkg::prc_bytes_t bytes
);

  // unlisted codes fall back to 512 bytes
  always_comb begin
    unique case (code)
      3'h1: bytes = 13'h0080;
      3'h2: bytes = 13'h0100;
      3'h4: bytes = 13'h0400;
      3'h5: bytes = 13'h0800;
      3'h6: bytes = 13'h1000;
      default: bytes = 13'h0200;
    endcase
  end

endmodule : prc_bcnt_dec

//--- prc_park_arb.sv
// secondary bus arbiter with selectable parking
`timescale 1ns/1ps
module prc_park_arb #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic park_self,
  input wire logic [N-1:0] req,
  output logic [N-1:0] gnt,
  output logic gnt_self
);

  logic [N-1:0] first_req;
  logic [N-1:0] next_gnt;
  logic next_self;

  // fixed priority by index; a master keeps its grant while it still asks
  assign first_req = req & (~req + {{(N-1){1'b0}}, 1'b1});

  always_comb begin
    next_gnt = gnt;
    next_self = gnt_self;
    if ((gnt & req) != '0) begin
      next_self = 1'b0;
    end else if (req != '0) begin
      next_gnt = first_req;
      next_self = 1'b0;
    end else if (park_self) begin
      next_gnt = '0;
      next_self = 1'b1;
    end else if (gnt == '0 && !gnt_self) begin
      next_gnt = '0;
    end else begin
      next_self = 1'b0;
      next_gnt = gnt_self ? '0 : gnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gnt <= '0;
      gnt_self <= 1'b0;
    end else if (ce) begin
      gnt <= next_gnt;
      gnt_self <= next_self;
    end
  end

endmodule : prc_park_arb

//--- prc_top.sv
// read prefetch and delayed read control of the pci side of the bridge
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "prc_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module prc_top #(
  parameter int N_MASTERS = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // axi4-lite register port
  input wire logic [`PRC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PRC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // secondary arbiter
  input wire logic [N_MASTERS-1:0] arb_req,
  output logic [N_MASTERS-1:0] arb_gnt,
  output logic arb_gnt_self,
  // memory read requests from a pci master
  input wire logic rd_valid,
  input wire logic [1:0] rd_cmd,
  input wire logic [31:0] rd_addr,
  input wire logic [3:0] rd_be,
  input wire logic rd_prefetchable,
  input wire logic cpl_done,
  input wire logic xfer_end,
  input wire logic xfer_by_master,
  input wire logic discard_expire,
  output logic rsp_valid,
  output logic rsp_retry,
  output logic rsp_hit,
  output logic fetch_valid,
  output prc_pkg::prc_fetch_e fetch_kind,
  output prc_pkg::prc_bytes_t fetch_bytes,
  // configuration cycles
  input wire logic cfg_valid,
  input wire logic [31:0] cfg_addr,
  output logic cfg_out_valid,
  output logic cfg_type1,
  output logic [31:0] cfg_out_addr,
  // control levels to the rest of the bridge
  output logic pref_dyn_en,
  output logic pred_en,
  output logic malf_chk_en
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl, w_data, tag_addr;
  logic mto_stat, aw_held, w_held, tag_mode;
  logic [`PRC_ADDR_W-1:0] aw_addr;
  logic [3:0] w_strb, tag_be;
  prc_pkg::prc_state_e state, next_state;
  logic [1:0] tag_cmd;
  wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = do_write && (aw_addr == `PRC_CTRL_OFF);
  wire wr_stat = do_write && (aw_addr == `PRC_STAT_OFF);
  wire wr_hit = wr_ctrl || wr_stat;
  wire [31:0] next_ctrl = (ctrl & ~(strb_mask & `PRC_CTRL_WMASK))
                        | (w_data & strb_mask & `PRC_CTRL_WMASK);
  wire mto_clear = wr_stat && w_strb[0] && w_data[`PRC_STAT_MTO];
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_is_ctrl = (s_axi_araddr == `PRC_CTRL_OFF);
  wire rd_is_stat = (s_axi_araddr == `PRC_STAT_OFF);
  wire [31:0] stat_word = {29'h0000_0000, state == prc_pkg::PRC_RETAIN,
                           state != prc_pkg::PRC_IDLE, mto_stat};
  wire [31:0] rd_word = rd_is_ctrl ? ctrl : (rd_is_stat ? stat_word : 32'h0000_0000);

  ////////////////////////////////////////////////////////////////////////////////
  // mode fields and byte count
  wire [1:0] mrm_mode = ctrl[`PRC_MRM_LO+1:`PRC_MRM_LO];
  wire [1:0] mrl_mode = ctrl[`PRC_MRL_LO+1:`PRC_MRL_LO];
  wire [1:0] mr_mode = ctrl[`PRC_MR_LO+1:`PRC_MR_LO];
  wire sdr_on = ctrl[`PRC_BIT_SDR];
  wire [1:0] cur_mode = (rd_cmd == `PRC_CMD_MRM) ? mrm_mode :
                        (rd_cmd == `PRC_CMD_MRL) ? mrl_mode : mr_mode;
  prc_pkg::prc_bytes_t max_bytes;
  prc_bcnt_dec u_bcnt (
    .code(ctrl[`PRC_BCNT_LO+2:`PRC_BCNT_LO]),
    .bytes(max_bytes)
  );
  prc_pkg::prc_fetch_e req_kind;
  always_comb begin
    if (!rd_prefetchable) begin
      req_kind = prc_pkg::PRC_FETCH_EXACT;
    end else if (rd_cmd == `PRC_CMD_MR) begin
      unique case (mr_mode)
        `PRC_MODE_FULL: req_kind = prc_pkg::PRC_FETCH_FULL;
        `PRC_MODE_11: req_kind = prc_pkg::PRC_FETCH_ONE_DW;
        default: req_kind = prc_pkg::PRC_FETCH_LINE;
      endcase
    end else if (cur_mode == `PRC_MODE_LINE) begin
      req_kind = prc_pkg::PRC_FETCH_LINE;
    end else begin
      req_kind = prc_pkg::PRC_FETCH_FULL;
    end
  end
  // retention after the transfer ends: mode 11 of MRM and MRL always keeps full prefetch data, mode 01 depends on who ended it
  wire [1:0] tag_mfield = (tag_cmd == `PRC_CMD_MRM) ? mrm_mode : mrl_mode;
  wire keep_any = (tag_cmd != `PRC_CMD_MR) && (tag_mfield == `PRC_MODE_11);
  wire keep_bridge = (tag_cmd == `PRC_CMD_MRM) && (mrm_mode == `PRC_MODE_01)
                     && !xfer_by_master;
  wire keep_master = (tag_cmd == `PRC_CMD_MRL) && (mrl_mode == `PRC_MODE_01)
                     && xfer_by_master;
  wire keep_data = tag_mode && (keep_any || keep_bridge || keep_master);

  ////////////////////////////////////////////////////////////////////////////////
  // delayed read tracking
  wire same_place = (rd_addr == tag_addr) && (rd_be == tag_be);
  wire cmd_ok = (rd_cmd == tag_cmd) || sdr_on;
  wire match = same_place && cmd_ok;
  wire held_data = (state == prc_pkg::PRC_READY) || (state == prc_pkg::PRC_RETAIN);
  wire give_data = rd_valid && held_data && match;
  wire drop_held = discard_expire && held_data;
  wire start_new = rd_valid && !give_data
                   && ((state == prc_pkg::PRC_IDLE)
                       || (state == prc_pkg::PRC_RETAIN && !same_place));

  always_comb begin
    next_state = state;
    unique case (state)
      prc_pkg::PRC_IDLE: begin
        if (start_new) next_state = prc_pkg::PRC_PENDING;
      end
      prc_pkg::PRC_PENDING: begin
        if (cpl_done) next_state = prc_pkg::PRC_READY;
      end
      prc_pkg::PRC_READY: begin
        if (drop_held) next_state = prc_pkg::PRC_IDLE;
        else if (xfer_end) next_state = keep_data ? prc_pkg::PRC_RETAIN : prc_pkg::PRC_IDLE;
      end
      prc_pkg::PRC_RETAIN: begin
        if (drop_held) next_state = prc_pkg::PRC_IDLE;
        else if (start_new) next_state = prc_pkg::PRC_PENDING;
        else if (give_data) next_state = prc_pkg::PRC_READY;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PRC_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PRC_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_is_ctrl || rd_is_stat) ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl <= `PRC_CTRL_RESET;
      mto_stat <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) ctrl <= next_ctrl;
      // a drop in the clearing cycle still leaves the bit set
      mto_stat <= drop_held || (mto_stat && !mto_clear);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request handling
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= prc_pkg::PRC_IDLE;
      tag_cmd <= `PRC_CMD_MR;
      tag_addr <= 32'h0000_0000;
      tag_be <= 4'h0;
      tag_mode <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (start_new) begin
        tag_cmd <= rd_cmd;
        tag_addr <= rd_addr;
        tag_be <= rd_be;
        tag_mode <= (req_kind == prc_pkg::PRC_FETCH_FULL);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_retry <= 1'b0;
      rsp_hit <= 1'b0;
      fetch_valid <= 1'b0;
      fetch_kind <= prc_pkg::PRC_FETCH_EXACT;
      fetch_bytes <= '0;
    end else if (ce) begin
      rsp_valid <= rd_valid;
      rsp_retry <= rd_valid && !give_data;
      rsp_hit <= give_data;
      fetch_valid <= start_new;
      if (start_new) begin
        fetch_kind <= req_kind;
        fetch_bytes <= (req_kind == prc_pkg::PRC_FETCH_FULL) ? max_bytes : '0;
      end
    end
  end
  // on conversion bit 0 is ignored and forced to the type 1 marker; otherwise the address passes unchanged
  wire cfg_conv = ctrl[`PRC_BIT_CFG_CONV] && (cfg_addr[31:28] == `PRC_CFG_TOP);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_out_valid <= 1'b0;
      cfg_type1 <= 1'b0;
      cfg_out_addr <= 32'h0000_0000;
      pref_dyn_en <= 1'b1;
      pred_en <= 1'b1;
      malf_chk_en <= 1'b0;
    end else if (ce) begin
      cfg_out_valid <= cfg_valid;
      if (cfg_valid) begin
        cfg_type1 <= cfg_conv;
        cfg_out_addr <= cfg_conv ? {cfg_addr[31:1], 1'b1} : cfg_addr;
      end
      pref_dyn_en <= !ctrl[`PRC_BIT_DYN_DIS];
      pred_en <= !ctrl[`PRC_BIT_PRED_DIS];
      malf_chk_en <= ctrl[`PRC_BIT_MALF];
    end
  end
  prc_park_arb #(
    .N(N_MASTERS)
  ) u_arb (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .park_self(ctrl[`PRC_BIT_PARK]),
    .req(arb_req),
    .gnt(arb_gnt),
    .gnt_self(arb_gnt_self)
  );

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_full_req;
    ce && start_new && req_kind == prc_pkg::PRC_FETCH_FULL;
  endsequence

  sequence s_drop;
    ce && drop_held;
  endsequence
  a_park_self_idle: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ctrl[`PRC_BIT_PARK] && arb_req == '0 |=> arb_gnt_self && arb_gnt == '0)
    else $error("idle bus not parked on own port");
  a_dyn_level: assert property (@(posedge clk) disable iff (!rst_b)
    ce && $past(ce) |-> pref_dyn_en == !$past(ctrl[`PRC_BIT_DYN_DIS]))
    else $error("dynamic prefetch enable wrong");
  a_pred_level: assert property (@(posedge clk) disable iff (!rst_b)
    ce && $past(ce) |-> pred_en == !$past(ctrl[`PRC_BIT_PRED_DIS]))
    else $error("prediction enable wrong");
  a_cfg_convert: assert property (@(posedge clk) disable iff (!rst_b)
    ce && cfg_valid |=> cfg_type1 == ($past(ctrl[`PRC_BIT_CFG_CONV])
                        && $past(cfg_addr[31:28]) == 4'hf))
    else $error("configuration conversion wrong");
  a_cfg_bit0: assert property (@(posedge clk) disable iff (!rst_b)
    ce && cfg_valid && cfg_conv |=> cfg_out_addr[0] && cfg_out_addr[31:1] == $past(cfg_addr[31:1]))
    else $error("converted address wrong");
  a_nonpref_exact: assert property (@(posedge clk) disable iff (!rst_b)
    ce && start_new && !rd_prefetchable |=> fetch_kind == prc_pkg::PRC_FETCH_EXACT)
    else $error("non-prefetchable read prefetched");
  a_mr_one_dw: assert property (@(posedge clk) disable iff (!rst_b)
    ce && start_new && rd_prefetchable && rd_cmd == `PRC_CMD_MR && mr_mode == 2'h3
    |=> fetch_kind == prc_pkg::PRC_FETCH_ONE_DW)
    else $error("one dword disconnect not chosen");
  a_full_bytes: assert property (@(posedge clk) disable iff (!rst_b)
    s_full_req |=> fetch_valid && fetch_bytes == $past(max_bytes))
    else $error("full prefetch byte count wrong");
  a_cmd_retry: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rd_valid && !sdr_on && rd_cmd != tag_cmd |=> rsp_retry && !rsp_hit)
    else $error("changed command not retried");
  a_sdr_hit: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rd_valid && sdr_on && held_data && same_place |=> rsp_hit)
    else $error("special mode match not served");
  a_drop_status: assert property (@(posedge clk) disable iff (!rst_b)
    s_drop |=> mto_stat ##0 state == prc_pkg::PRC_IDLE)
    else $error("dropped completion not flagged");
  a_keep_any: assert property (@(posedge clk) disable iff (!rst_b)
    ce && state == prc_pkg::PRC_READY && xfer_end && !discard_expire && tag_mode
    && tag_cmd == `PRC_CMD_MRM && mrm_mode == 2'h3 |=> state == prc_pkg::PRC_RETAIN)
    else $error("leftover data not kept");
endmodule : prc_top

//--- prc_link_model.sv
// far side model: answers each upstream read that arrives while it is idle with a completion, alternately fast and slow
`timescale 1ns/1ps
module prc_link_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fetch_valid,
  output logic cpl_done
);
  logic busy;
  logic slow;
  logic [3:0] cnt;
  // alternating latency so the bench sees both a quick and a late completion
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      slow <= 1'b0;
      cnt <= 4'h0;
      cpl_done <= 1'b0;
    end else begin
      cpl_done <= 1'b0;
      if (fetch_valid && !busy) begin
        busy <= 1'b1;
        cnt <= slow ? 4'h7 : 4'h2;
        slow <= !slow;
      end else if (busy) begin
        if (cnt == 4'h0) begin
          busy <= 1'b0;
          cpl_done <= 1'b1;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule : prc_link_model

//--- tb_pci_read_prefetch_control.sv
// self-checking bench of the read prefetch control block
`timescale 1ns/1ps
`include "prc_consts.svh"
module tb_pci_read_prefetch_control;
  logic clk, rst_b, ce;
  logic [`PRC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_addr, cfg_addr, cfg_out_addr, rv;
  logic [3:0] s_axi_wstrb, arb_req, arb_gnt, rd_be, be_use;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_cmd, rr;
  logic arb_gnt_self, rd_valid, rd_prefetchable, cpl_done, xfer_end, xfer_by_master;
  logic discard_expire, rsp_valid, rsp_retry, rsp_hit, fetch_valid, cfg_valid;
  logic cfg_out_valid, cfg_type1, pref_dyn_en, pred_en, malf_chk_en;
  prc_pkg::prc_fetch_e fetch_kind;
  prc_pkg::prc_bytes_t fetch_bytes;
  int fails, cmp_count;

  prc_top #(.N_MASTERS(4)) u_dut (.clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .arb_req, .arb_gnt, .arb_gnt_self, .rd_valid,
    .rd_cmd, .rd_addr, .rd_be, .rd_prefetchable, .cpl_done, .xfer_end, .xfer_by_master,
    .discard_expire, .rsp_valid, .rsp_retry, .rsp_hit, .fetch_valid, .fetch_kind,
    .fetch_bytes, .cfg_valid, .cfg_addr, .cfg_out_valid, .cfg_type1, .cfg_out_addr,
    .pref_dyn_en, .pred_en, .malf_chk_en);
  prc_link_model u_link (.clk, .rst_b, .fetch_valid, .cpl_done);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task tmo;
    fails++;
    $display("MISMATCH %0t wait timed out", $time);
    final_report();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !(aw_ok && w_ok); n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    for (; n < 100 && s_axi_bvalid !== 1'b1; n++) @(posedge clk);
    if (n >= 100) tmo();
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) break;
    end
    s_axi_arvalid <= 1'b0;
    for (; n < 100 && s_axi_rvalid !== 1'b1; n++) @(posedge clk);
    if (n >= 100) tmo();
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  function automatic logic [31:0] cv(input logic [1:0] mrm, mrl, mr, input logic [2:0] b,
                                     input logic sdr);
    return {17'h0_0000, b, 1'b0, sdr, mr, mrl, mrm, 4'h0};
  endfunction : cv
  function automatic logic [12:0] bc(input logic [2:0] c);
    case (c)
      3'h1: return 13'h0080;
      3'h2: return 13'h0100;
      3'h4: return 13'h0400;
      3'h5: return 13'h0800;
      3'h6: return 13'h1000;
      default: return 13'h0200;
    endcase
  endfunction : bc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic rd_req(input logic [1:0] c, input logic [31:0] a, input logic p,
                        input logic hit);
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_cmd <= c;
    rd_addr <= a;
    rd_be <= be_use;
    rd_prefetchable <= p;
    @(posedge clk);
    rd_valid <= 1'b0;
    #1;
    chk(rsp_valid, 1'b1, "rsp_valid");
    chk(rsp_hit, hit, "rsp_hit");
    chk(rsp_retry, !hit, "rsp_retry");
  endtask : rd_req
  task automatic pulse_end(input logic bym);
    @(posedge clk);
    xfer_end <= 1'b1;
    xfer_by_master <= bym;
    @(posedge clk);
    xfer_end <= 1'b0;
  endtask : pulse_end
  task automatic wait_cpl;
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (cpl_done === 1'b1) break;
    end
    if (n >= 40) tmo();
  endtask : wait_cpl
  // retry with a new fetch, completion, matching repeat hits, transfer ends
  task automatic full_read(input logic [1:0] c, input logic [31:0] a, input logic p,
                           input prc_pkg::prc_fetch_e k, input logic [12:0] b,
                           input logic bym);
    rd_req(c, a, p, 1'b0);
    chk(fetch_valid, 1'b1, "fetch_valid");
    chk(fetch_kind, k, "fetch_kind");
    chk(fetch_bytes, b, "fetch_bytes");
    wait_cpl();
    rd_req(c, a, p, 1'b1);
    pulse_end(bym);
  endtask : full_read
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    axi_rd(`PRC_CTRL_OFF);
    chk(rv, `PRC_CTRL_RESET, "ctrl reset");
    axi_rd(`PRC_STAT_OFF);
    chk(rv, 32'h0000_0000, "status reset");
    chk({pref_dyn_en, pred_en, malf_chk_en}, 3'b110, "levels reset");
    axi_rd(12'h100);
    chk(rv, 32'h0000_0000, "unmapped read data");
    chk(rr, `PRC_RESP_SLVERR, "unmapped read resp");
    axi_wr(12'h104, 32'hffff_ffff);
    chk(rr, `PRC_RESP_SLVERR, "unmapped write");
  endtask : t_reset
  task automatic t_levels;
    axi_wr(`PRC_CTRL_OFF, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    #1;
    chk({pref_dyn_en, pred_en, malf_chk_en}, 3'b001, "levels set");
    axi_rd(`PRC_CTRL_OFF);
    chk(rv, `PRC_CTRL_WMASK, "ctrl readback");
  endtask : t_levels
  task automatic t_modes;
    logic [1:0] mm [3];
    prc_pkg::prc_fetch_e kk [3];
    int i;
    mm = '{2'h0, 2'h2, 2'h3};
    kk = '{prc_pkg::PRC_FETCH_LINE, prc_pkg::PRC_FETCH_FULL, prc_pkg::PRC_FETCH_ONE_DW};
    for (i = 0; i < 3; i++) begin
      axi_wr(`PRC_CTRL_OFF, cv(2'h2, 2'h0, mm[i], 3'h0, 1'b0));
      full_read(`PRC_CMD_MR, 32'h1000_0000 + i * 64, 1'b1, kk[i],
                (i == 1) ? 13'h0200 : 13'h0000, 1'b1);
    end
    full_read(`PRC_CMD_MRL, 32'h1100_0000, 1'b1, prc_pkg::PRC_FETCH_LINE, 13'h0, 1'b1);
    full_read(`PRC_CMD_MR, 32'h1200_0000, 1'b0, prc_pkg::PRC_FETCH_EXACT, 13'h0, 1'b1);
    axi_wr(`PRC_CTRL_OFF, cv(2'h0, 2'h0, 2'h0, 3'h0, 1'b0));
    full_read(`PRC_CMD_MRM, 32'h1300_0000, 1'b1, prc_pkg::PRC_FETCH_LINE, 13'h0, 1'b1);
  endtask : t_modes
  task automatic t_bcnt;
    int c;
    for (c = 0; c < 8; c++) begin
      axi_wr(`PRC_CTRL_OFF, cv(2'h2, 2'h0, 2'h0, c[2:0], 1'b0));
      full_read(`PRC_CMD_MRM, 32'h2000_0000 + c * 256, 1'b1, prc_pkg::PRC_FETCH_FULL,
                bc(c[2:0]), 1'b1);
    end
  endtask : t_bcnt
  task automatic t_cmdchg;
    axi_wr(`PRC_CTRL_OFF, cv(2'h2, 2'h0, 2'h0, 3'h0, 1'b0));
    rd_req(`PRC_CMD_MRM, 32'h3000_0040, 1'b1, 1'b0);
    wait_cpl();
    rd_req(`PRC_CMD_MRL, 32'h3000_0040, 1'b1, 1'b0);
    axi_wr(`PRC_CTRL_OFF, cv(2'h2, 2'h0, 2'h0, 3'h0, 1'b1));
    be_use = 4'h3;
    rd_req(`PRC_CMD_MRL, 32'h3000_0040, 1'b1, 1'b0);
    chk(fetch_valid, 1'b0, "no fetch on enable mismatch");
    be_use = 4'hf;
    rd_req(`PRC_CMD_MRL, 32'h3000_0040, 1'b1, 1'b1);
    pulse_end(1'b1);
  endtask : t_cmdchg
  // modes 11 and 01 of both commands, each ended by a side after which the data stays
  task automatic t_retain;
    int i;
    logic [1:0] md, cm;
    logic bym;
    for (i = 0; i < 4; i++) begin
      md = i[0] ? `PRC_MODE_01 : `PRC_MODE_11;
      cm = i[1] ? `PRC_CMD_MRL : `PRC_CMD_MRM;
      bym = !(i[0] ^ i[1]);
      axi_wr(`PRC_CTRL_OFF, cv(md, md, 2'h0, 3'h0, 1'b0));
      full_read(cm, 32'h4000_0000, 1'b1, prc_pkg::PRC_FETCH_FULL, 13'h0200,
                bym);
      axi_rd(`PRC_STAT_OFF);
      chk(rv, 32'h0000_0006, "retaining status");
      rd_req(cm, 32'h4000_0000, 1'b1, 1'b1);
      @(posedge clk);
      discard_expire <= 1'b1;
      @(posedge clk);
      discard_expire <= 1'b0;
      axi_rd(`PRC_STAT_OFF);
      chk(rv, 32'h0000_0001, "timeout status set");
      axi_wr(`PRC_STAT_OFF, 32'h0000_0001);
      axi_rd(`PRC_STAT_OFF);
      chk(rv, 32'h0000_0000, "timeout status cleared");
      rd_req(cm, 32'h4000_0000, 1'b1, 1'b0);
      wait_cpl();
      rd_req(cm, 32'h4000_0000, 1'b1, 1'b1);
      pulse_end(bym);
      @(posedge clk);
      discard_expire <= 1'b1;
      @(posedge clk);
      discard_expire <= 1'b0;
      axi_rd(`PRC_STAT_OFF);
      chk(rv, 32'h0000_0001, "retained data dropped");
      axi_wr(`PRC_STAT_OFF, 32'h0000_0001);
    end
  endtask : t_retain
  task automatic cfg_one(input logic [31:0] a, input logic t1, input logic [31:0] ea);
    @(posedge clk);
    cfg_valid <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_valid <= 1'b0;
    #1;
    chk({cfg_out_valid, cfg_type1}, {1'b1, t1}, "cfg type");
    chk(cfg_out_addr, ea, "cfg addr");
  endtask : cfg_one
  task automatic t_cfg;
    cfg_one(32'hf012_3400, 1'b0, 32'hf012_3400);
    axi_wr(`PRC_CTRL_OFF, 32'h0000_0008);
    cfg_one(32'hf012_3400, 1'b1, 32'hf012_3401);
    cfg_one(32'h7012_3400, 1'b0, 32'h7012_3400);
  endtask : t_cfg
  task automatic t_arb;
    axi_wr(`PRC_CTRL_OFF, 32'h0000_0000);
    arb_req <= 4'h2;
    repeat (3) @(posedge clk);
    arb_req <= 4'h0;
    repeat (3) @(posedge clk);
    #1;
    chk({arb_gnt, arb_gnt_self}, 5'h04, "park last");
    axi_wr(`PRC_CTRL_OFF, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #1;
    chk({arb_gnt, arb_gnt_self}, 5'h01, "park self");
    @(posedge clk);
    ce <= 1'b0;
    arb_req <= 4'h8;
    repeat (3) @(posedge clk);
    #1;
    chk({arb_gnt, arb_gnt_self}, 5'h01, "grant frozen by enable");
    @(posedge clk);
    ce <= 1'b1;
    arb_req <= 4'h0;
  endtask : t_arb
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    cmp_count = 0;
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {rd_valid, rd_prefetchable, xfer_end, xfer_by_master, discard_expire, cfg_valid} = '0;
    ce = 1'b1;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    arb_req = '0;
    rd_cmd = '0;
    rd_addr = '0;
    rd_be = '0;
    be_use = 4'hf;
    cfg_addr = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_levels();
    t_modes();
    t_bcnt();
    t_cmdchg();
    t_retain();
    t_cfg();
    t_arb();
    final_report();
  end
endmodule : tb_pci_read_prefetch_control
